// *** inc/sdcc_pkg.sv ***
// package: constants, states and carriers for sensor drive control
package sdcc_pkg;

  // ********************
  // register map
  // ********************
  localparam logic [7:0] ADDR_CH0_DRIVE = 8'h1E; // channel0_drive_setting
  localparam logic [7:0] ADDR_CH1_DRIVE = 8'h1F; // channel1_drive_setting
  localparam logic [7:0] ADDR_CH2_DRIVE = 8'h20; // channel2_drive_setting
  localparam logic [7:0] ADDR_CH3_DRIVE = 8'h21; // channel3_drive_setting
  localparam int DRV_HI = 15; // drive_current_code field
  localparam int DRV_LO = 11;
  localparam int CAL_HI = 10; // calibrated_drive_code field
  localparam int CAL_LO = 6;
  localparam logic [4:0] DRV_RESET = 5'h00; // value after reset
  localparam logic [4:0] CAL_RESET = 5'h00;
  localparam logic [4:0] SEARCH_START = 5'h10; // first trial code
  localparam logic [2:0] SEARCH_BIT0 = 3'h4; // first trial bit
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam int NUM_CH = 4;

  // ********************
  // types
  // ********************
  typedef logic [4:0] sdcc_code_t;
  typedef logic [1:0] sdcc_ch_t;

  typedef enum logic [2:0] {
    S_SLEEP = 3'b000,
    S_SEARCH = 3'b001,
    S_SETTLE = 3'b010,
    S_CONV = 3'b011,
    S_GROUND = 3'b100
  } sdcc_state_e;

  // configuration bits that steer the sequencer
  typedef struct packed {
    logic sleep;          // sleep or shutdown requested
    logic fixed_drive_override;
    logic auto_amp_dis;
    logic scan_en;        // multi-channel scanning
    sdcc_ch_t last_ch;    // last channel of the scan
    sdcc_ch_t sel_ch;     // channel in single-channel mode
    logic [15:0] settle_cycle_count;
    logic [15:0] conversion_cycle_count;
  } sdcc_cfg_s;

  // amplitude monitor from the analog front end, one bit per channel
  typedef struct packed {
    logic [3:0] amp_low;   // amplitude below 1.2 V peak
    logic [3:0] amp_high;  // amplitude above 1.8 V peak
    logic [3:0] osc_alive; // oscillation present
  } sdcc_amp_s;

endpackage : sdcc_pkg

// *** rtl/sdcc_core.sv ***
// sensor drive current control: registers, grounding, scan and search
// Contract
// RQ1: each channel holds 5-bit monotonic drive code
// RQ2: code used only when correction off, override set
// RQ3: ground both pins of inactive channels
// RQ4: sleep or shutdown grounds every channel
// RQ5: drive only converted channel, its interval
// RQ6: ground finished channel, then activate next
// RQ7: auto search on entering active mode
// RQ8: search targets 1.2 to 1.8 V peak
// RQ9: host clears override for automatic selection
// RQ10: host sets override for normal operation
// RQ11: host sleeps device, programs counts, clears override
// RQ12: host wakes device, waits one measurement
// RQ13: host reads calibrated code bits 10:6
// RQ14: host writes saved code into bits 15:11
// RQ15: stopped oscillation gives all-zero samples
// RQ16: host recalibrates each differing channel
// RQ17: host should prefer fixed drive code
// RQ18: host may change code by target position
// RQ19: device writes calibrated field, host writes code
`timescale 1ns/1ns
module sdcc_core (
  input wire logic clk, // 20 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // read data, registered
  input wire sdcc_pkg::sdcc_cfg_s cfg, // sequencer configuration
  input wire sdcc_pkg::sdcc_amp_s amp, // amplitude monitor
  input wire logic [11:0] sample_in, // raw result of active channel
  output logic [3:0] drive_en, // excitation on, per channel
  output logic [3:0] ground_en, // pins grounded, per channel
  output logic [4:0] drive_code_out, // code applied to driver
  output logic [1:0] active_ch, // channel in service
  output logic conv_done, // one-cycle pulse at conversion end
  output logic [11:0] sample_out, // last sample
  output logic sample_valid // one-cycle pulse with a sample_out loaded while sleep is low
);
  import sdcc_pkg::*;

  // ********************
  // helper functions
  // ********************
  // one-hot mask of a channel
  function automatic logic [3:0] ch_mask(input sdcc_ch_t ch);
    ch_mask = 4'h1 << ch;
  endfunction : ch_mask

  // channel index of a drive-setting address
  function automatic sdcc_ch_t addr_ch(input logic [7:0] a);
    addr_ch = sdcc_ch_t'(a - ADDR_CH0_DRIVE);
  endfunction : addr_ch

  // ********************
  // state
  // ********************
  sdcc_state_e st_r, st_nxt;
  sdcc_code_t drv_r [NUM_CH];
  sdcc_code_t cal_r [NUM_CH];
  sdcc_ch_t ch_r, ch_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  sdcc_code_t trial_r, trial_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic search_r, search_nxt;
  logic cal_we;

  // ********************
  // decode
  // ********************
  // address hit on one of the four drive-setting registers
  wire addr_hit = (reg_addr >= ADDR_CH0_DRIVE) &&
                  (reg_addr <= ADDR_CH3_DRIVE);
  wire sdcc_ch_t wr_ch = addr_ch(reg_addr);
  wire use_fixed = cfg.auto_amp_dis & cfg.fixed_drive_override;
  wire sdcc_ch_t next_ch = cfg.scan_en ?
       ((ch_r == cfg.last_ch) ? 2'h0 : sdcc_ch_t'(ch_r + 2'h1)) : cfg.sel_ch;
  wire sdcc_ch_t first_ch = cfg.scan_en ? 2'h0 : cfg.sel_ch;
  wire cnt_end_settle = (cnt_r >= cfg.settle_cycle_count);
  wire cnt_end_conv = (cnt_r >= cfg.conversion_cycle_count);
  wire a_low = amp.amp_low[ch_r];
  wire a_high = amp.amp_high[ch_r];
  wire a_ok = !a_low && !a_high;
  wire osc_ok = amp.osc_alive[ch_r];
  // trial code after judging the current bit
  wire sdcc_code_t judged = a_high ?
       (trial_r & ~(sdcc_code_t'(5'h01) << bit_r)) : trial_r;
  wire search_done = a_ok || (bit_r == 3'h0);
  wire in_drive = (st_r == S_SEARCH) || (st_r == S_SETTLE) ||
                  (st_r == S_CONV);

  // ********************
  // sequencer
  // ********************
  always_comb begin
    st_nxt = st_r;
    ch_nxt = ch_r;
    cnt_nxt = cnt_r + 16'h0001;
    trial_nxt = trial_r;
    bit_nxt = bit_r;
    search_nxt = search_r;
    cal_we = 1'b0;
    case (st_r)
      S_SLEEP: begin
        cnt_nxt = CNT_RESET;
        ch_nxt = first_ch;
        trial_nxt = SEARCH_START;
        bit_nxt = SEARCH_BIT0;
        if (!cfg.sleep) begin
          search_nxt = !cfg.fixed_drive_override; // see RQ7
          st_nxt = cfg.fixed_drive_override ? S_SETTLE : S_SEARCH;
        end
      end
      S_SEARCH: begin
        // successive approximation toward the amplitude window
        if (cnt_end_settle) begin // see RQ8
          cnt_nxt = CNT_RESET;
          if (search_done) begin
            cal_we = 1'b1;
            trial_nxt = judged;
            st_nxt = S_GROUND;
          end else begin
            trial_nxt = judged | (sdcc_code_t'(5'h01) << (bit_r - 3'h1));
            bit_nxt = bit_r - 3'h1;
          end
        end
      end
      S_SETTLE: begin
        if (cnt_end_settle) begin
          cnt_nxt = CNT_RESET;
          st_nxt = S_CONV;
        end
      end
      S_CONV: begin
        if (cnt_end_conv) begin // see RQ5
          cnt_nxt = CNT_RESET;
          st_nxt = S_GROUND;
        end
      end
      S_GROUND: begin
        // one cycle with all pins grounded, then the next channel
        cnt_nxt = CNT_RESET;
        trial_nxt = SEARCH_START;
        bit_nxt = SEARCH_BIT0;
        if (search_r && (!cfg.scan_en || ch_r == cfg.last_ch)) begin
          search_nxt = 1'b0;
          ch_nxt = first_ch;
          st_nxt = S_SETTLE;
        end else begin
          ch_nxt = next_ch; // see RQ6
          st_nxt = search_r ? S_SEARCH : S_SETTLE;
        end
      end
      default: begin
        st_nxt = S_SLEEP;
      end
    endcase
    if (cfg.sleep) begin
      st_nxt = S_SLEEP; // see RQ4
    end
  end

  // state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= S_SLEEP;
      ch_r <= 2'h0;
      cnt_r <= CNT_RESET;
      trial_r <= SEARCH_START;
      bit_r <= SEARCH_BIT0;
      search_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      cnt_r <= cnt_nxt;
      trial_r <= trial_nxt;
      bit_r <= bit_nxt;
      search_r <= search_nxt;
    end
  end

  // ********************
  // drive-setting registers
  // ********************
  // host writes the code field, the search writes the calibrated field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        drv_r[i] <= DRV_RESET;
        cal_r[i] <= CAL_RESET;
      end
    end else begin
      if (reg_wr && addr_hit) begin
        drv_r[wr_ch] <= reg_wdata[DRV_HI:DRV_LO]; // see RQ1
      end
      if (cal_we) begin
        cal_r[ch_r] <= judged; // see RQ19
      end
    end
  end

  // read port and outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
      drive_en <= 4'h0;
      ground_en <= 4'hF;
      drive_code_out <= DRV_RESET;
      active_ch <= 2'h0;
      conv_done <= 1'b0;
      sample_out <= 12'h000;
      sample_valid <= 1'b0;
    end else begin
      reg_rdata <= addr_hit ? {drv_r[wr_ch], cal_r[wr_ch], 6'h00} : 16'h0000;
      drive_en <= (in_drive && st_nxt == st_r) ? ch_mask(ch_r) : 4'h0; // see RQ5
      ground_en <= (in_drive && st_nxt == st_r) ? ~ch_mask(ch_r) : 4'hF; // see RQ3
      drive_code_out <= (st_r == S_SEARCH) ? trial_r :
                        (use_fixed ? drv_r[ch_r] : cal_r[ch_r]); // see RQ2
      active_ch <= ch_r;
      conv_done <= (st_r == S_CONV) && cnt_end_conv;
      sample_valid <= (st_r == S_CONV) && cnt_end_conv && !cfg.sleep;
      if ((st_r == S_CONV) && cnt_end_conv) begin
        sample_out <= osc_ok ? sample_in : 12'h000; // see RQ15
      end
    end
  end

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_onehot_drive;
    $onehot0(drive_en) && ((drive_en & ground_en) == 4'h0);
  endproperty
  a_onehot_drive: assert property (p_onehot_drive) // see RQ5
    else $error("more than one channel driven");

  property p_ground_inactive;
    (drive_en != 4'h0) |-> (ground_en == ~drive_en);
  endproperty
  a_ground_inactive: assert property (p_ground_inactive) // see RQ3
    else $error("inactive channel not grounded");

  property p_sleep_ground;
    cfg.sleep ##1 cfg.sleep |=> (ground_en == 4'hF) && (drive_en == 4'h0);
  endproperty
  a_sleep_ground: assert property (p_sleep_ground) // see RQ4
    else $error("channel not grounded in sleep");

  property p_done_ground;
    conv_done |-> (ground_en == 4'hF) ##1 (st_r != S_GROUND);
  endproperty
  a_done_ground: assert property (p_done_ground) // see RQ6
    else $error("finished channel not grounded");

  property p_search_entry;
    (st_r == S_SLEEP && !cfg.sleep && !cfg.fixed_drive_override)
      |=> (st_r == S_SEARCH) && search_r;
  endproperty
  a_search_entry: assert property (p_search_entry) // see RQ7
    else $error("no search on active entry");

  property p_fixed_code;
    (st_r == S_CONV && use_fixed && $stable(drv_r[ch_r]) &&
     $past(st_r) == S_CONV && $stable(ch_r) && $past(use_fixed))
      |-> (drive_code_out == drv_r[ch_r]);
  endproperty
  a_fixed_code: assert property (p_fixed_code) // see RQ2
    else $error("programmed code not applied");

  property p_zero_sample;
    sample_valid |-> (sample_out ==
      ($past(osc_ok) ? $past(sample_in) : 12'h000));
  endproperty
  a_zero_sample: assert property (p_zero_sample) // see RQ15
    else $error("stopped oscillation not zeroed");

  property p_host_write;
    (reg_wr && addr_hit && !cal_we) |=>
      (drv_r[$past(wr_ch)] == $past(reg_wdata[DRV_HI:DRV_LO]));
  endproperty
  a_host_write: assert property (p_host_write) // see RQ1
    else $error("drive code write lost");

  property p_cal_update;
    cal_we |=> (cal_r[$past(ch_r)] == $past(judged)) && (st_r != S_SEARCH);
  endproperty
  a_cal_update: assert property (p_cal_update) // see RQ19
    else $error("calibrated field not updated");

  property p_search_window;
    (st_r == S_SEARCH && cnt_end_settle && a_ok)
      |-> cal_we && (judged == trial_r);
  endproperty
  a_search_window: assert property (p_search_window) // see RQ8
    else $error("in-window trial not kept");

endmodule : sdcc_core

// *** bench/sdcc_coil_model.sv ***
// model of the four lc sensor coils seen through the amplitude monitor
`timescale 1ns/1ns
module sdcc_coil_model (
  input wire logic [1:0] active_ch, // channel in service
  input wire logic [4:0] drive_code_out, // code applied to driver
  input wire logic [19:0] target, // in-window code, per channel
  input wire logic [3:0] dead, // coil that never oscillates
  output sdcc_pkg::sdcc_amp_s amp // amplitude monitor
);
  import sdcc_pkg::*;
  // ********************
  // amplitude versus code
  // ********************
  // only the serviced coil rings; the window is a single code
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      amp.amp_low[c] = (active_ch != c) ||
                       (drive_code_out < target[c*5+:5]);
      amp.amp_high[c] = (active_ch == c) &&
                        (drive_code_out > target[c*5+:5]);
      amp.osc_alive[c] = (active_ch == c) && !dead[c];
    end
  end
endmodule : sdcc_coil_model

// *** bench/test_sensor_drive_current_control.sv ***
// self-checking bench for the sensor drive current control core
`timescale 1ns/1ns
module test_sensor_drive_current_control;
  import sdcc_pkg::*;
  logic clk = 0;
  logic resetn = 0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  sdcc_cfg_s cfg = '0;
  sdcc_amp_s amp;
  logic [11:0] sample_in = 12'hA5C;
  logic [3:0] drive_en, ground_en, dead = 4'h0;
  logic [4:0] drive_code_out;
  logic [1:0] active_ch;
  logic conv_done, sample_valid, fixed = 0;
  logic [11:0] sample_out;
  logic [19:0] target = {5'h1F, 5'h03, 5'h15, 5'h0B};
  logic [4:0] codes [4] = '{5'h11, 5'h02, 5'h1E, 5'h09};
  logic [1:0] exp_ch = 2'h0;
  logic [1:0] last_ch = 2'h0;
  logic [1:0] order [$];
  int err_total = 0, checked = 0, cyc = 0, slp = 0;

  always #25 clk = ~clk;

  sdcc_core dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cfg(cfg), .amp(amp), .sample_in(sample_in), .drive_en(drive_en),
    .ground_en(ground_en), .drive_code_out(drive_code_out),
    .active_ch(active_ch), .conv_done(conv_done),
    .sample_out(sample_out), .sample_valid(sample_valid));

  sdcc_coil_model coils (.active_ch(active_ch),
    .drive_code_out(drive_code_out), .target(target), .dead(dead),
    .amp(amp));

  // ********************
  // helpers
  // ********************
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task results;
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task step;
    @(posedge clk);
    #5;
  endtask : step

  task wr(input logic [7:0] a, input logic [15:0] d);
    step;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    step;
    reg_wr = 0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] exp);
    step;
    reg_addr = a;
    step;
    step;
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd

  task wait_done(input int n);
    int k;
    k = 0;
    repeat (3000) begin
      @(negedge clk);
      if (conv_done === 1'b1) k++;
      if (k >= n) break;
    end
    chk("conv_done count", 16'(k), 16'(n));
  endtask : wait_done

  // ********************
  // port monitor
  // ********************
  always @(negedge clk) begin
    if (resetn) begin
      chk("ground_en", ground_en, 4'(~drive_en));
      chk("one hot", $onehot0(drive_en), 1'b1);
      slp = cfg.sleep ? slp + 1 : 0;
      if (slp > 2) chk("sleep ground", ground_en, 4'hF);
      for (int c = 0; c < 4; c++) begin
        if (drive_en[c]) begin
          last_ch = 2'(c);
          if (fixed)
            chk("drive_code_out", drive_code_out, codes[c]);
        end
      end
      // one visit per finished conversion, in scan or fixed order
      if (conv_done === 1'b1 && fixed) begin
        exp_ch = cfg.scan_en ? 2'(order.size()) : cfg.sel_ch;
        chk("active_ch", active_ch, exp_ch);
        order.push_back(last_ch);
      end
      if (sample_valid === 1'b1 && fixed)
        chk("sample_out", sample_out,
          dead[last_ch] ? 12'h000 : sample_in);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results;
    end
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    cfg.sleep = 1;
    cfg.scan_en = 1;
    cfg.last_ch = 2'h3;
    cfg.auto_amp_dis = 1;
    cfg.fixed_drive_override = 1;
    repeat (16) @(posedge clk);
    #5;
    resetn = 1;
    for (int a = 0; a < 4; a++) rd(8'(ADDR_CH0_DRIVE + a), 16'h0000);
    for (int a = 0; a < 4; a++)
      wr(8'(ADDR_CH0_DRIVE + a), {codes[a], 11'h7FF});
    wr(8'h22, 16'hFFFF);
    for (int a = 0; a < 4; a++)
      rd(8'(ADDR_CH0_DRIVE + a), {codes[a], 11'h000});
    rd(8'h22, 16'h0000);
    // calibration run with counts set while asleep
    cfg.settle_cycle_count = 16'h0003;
    cfg.conversion_cycle_count = 16'h0009;
    cfg.fixed_drive_override = 0;
    step;
    cfg.sleep = 0;
    wait_done(4);
    step;
    cfg.sleep = 1;
    repeat (6) step;
    // each channel keeps its own searched code
    for (int a = 0; a < 4; a++)
      rd(8'(ADDR_CH0_DRIVE + a),
        {codes[a], target[a*5+:5], 6'h00});
    // fixed drive with the saved codes, one dead coil
    for (int a = 0; a < 4; a++) begin
      codes[a] = target[a*5+:5];
      wr(8'(ADDR_CH0_DRIVE + a), {codes[a], 11'h000});
    end
    cfg.fixed_drive_override = 1;
    dead = 4'h4;
    fixed = 1;
    step;
    cfg.sleep = 0;
    wait_done(8);
    // code changed on the fly for a moved target
    step;
    fixed = 0;
    codes[1] = 5'h0C;
    wr(ADDR_CH1_DRIVE, {codes[1], 11'h000});
    wait_done(4);
    step;
    fixed = 1;
    wait_done(4);
    // single channel mode on one coil
    step;
    cfg.sleep = 1;
    repeat (4) step;
    cfg.scan_en = 0;
    cfg.sel_ch = 2'h1;
    step;
    cfg.sleep = 0;
    wait_done(3);
    step;
    cfg.sleep = 1;
    fixed = 0;
    repeat (20) step;
    chk("visits", order.size() >= 8, 1'b1);
    for (int i = 0; i < 8 && i < order.size(); i++)
      chk("scan order", order[i], 16'(i % 4));
    results;
  end
endmodule : test_sensor_drive_current_control
